// *** common/tlb_map_pkg.sv ***
// Constants shared by the translation-buffer lock-down and context map block.
// Assumes a single core clock and a coprocessor port driven by the core.
package tlb_map_pkg;
    localparam int ENTRY_COUNT = 64;
    localparam logic [5:0] LAST_ENTRY = 6'h3F;
    localparam logic [3:0] CRN_CACHE_LOCK = 4'h9;
    localparam logic [3:0] CRN_TLB_LOCK = 4'hA;
    localparam logic [3:0] CRN_CONTEXT = 4'hD;
    localparam logic [3:0] CRN_CONTROL = 4'h1;
    localparam logic [3:0] CRN_TLB_OPS = 4'h8;
    localparam logic [2:0] SEL_DATA = 3'h0;
    localparam logic [2:0] SEL_INSTR = 3'h1;
    localparam logic [3:0] CRM_BOTH = 4'h7;
    localparam logic [3:0] CRM_INSTR = 4'h5;
    localparam logic [3:0] CRM_DATA = 4'h6;
    localparam int BASE_LSB = 26;
    localparam int VICTIM_LSB = 20;
    localparam int PRESERVE_BIT = 0;
    localparam int CONTEXT_LSB = 25;
    localparam int REGION_LSB = 25;
    localparam int ENABLE_BIT = 0;
    localparam logic [31:0] LOCK_RESET = 32'h0000_0000;
    localparam logic [6:0] CONTEXT_RESET = 7'h00;
    localparam int CONTEXT_DELAY = 2;
    // Page sizes held in an entry
    typedef enum logic [1:0] {
        SIZE_SECTION,
        SIZE_LARGE,
        SIZE_SMALL,
        SIZE_TINY
    } page_size_type;
    // Domain settings
    localparam logic [1:0] DOM_NONE = 2'h0;
    localparam logic [1:0] DOM_CLIENT = 2'h1;
    localparam logic [1:0] DOM_MANAGER = 2'h3;
endpackage

// *** verif/tb_tlb_lockdown_and_context_map.sv ***
// Bench for the lock-down and context map block: register, mapping and refill tests.
// Assumes the walk model answers every request and the checker is bound separately.
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); err_total++; end end
module tb_tlb_lockdown_and_context_map;
    import tlb_map_pkg::*;
    logic clk_in, sys_rst_in, cp_wr_in, cp_rd_in, fetch_in, access_in, access_instr_in;
    logic access_write_in, access_priv_in, walk_done_in, walk_cache_in, walk_buf_in;
    logic walk_fault_in, hit_out, abort_out, cache_serve_out, offchip_out, cacheable_out;
    logic bufferable_out, walk_req_out, walk_instr_out, flt;
    logic [3:0] cp_crn_in, cp_crm_in, walk_domain_in, dly;
    logic [2:0] cp_sel_in;
    logic [7:0] walk_ap_in;
    logic [31:0] cp_wdata_in, cp_rdata_out, domain_access_in, core_addr_in, mapped_addr_in;
    logic [31:0] mapped_addr_out, phys_addr_out, walk_addr_out, walk_phys_in;
    page_size_type walk_size_in;
    int err_total, comparisons;
    logic [3:0] rsv [4] = '{4'hB, 4'hC, 4'hE, 4'hF};
    assign walk_buf_in = walk_cache_in;
    tlb_lockdown_and_context_map u_dut (.*);
    tlb_walk_model u_walk (.clk_in, .sys_rst_in, .req_in(walk_req_out),
        .addr_in(walk_addr_out), .dly_in(dly), .flt_in(flt), .done_out(walk_done_in),
        .phys_out(walk_phys_in), .fault_out(walk_fault_in), .cache_out(walk_cache_in));
    function automatic logic [31:0] lk(input logic [5:0] b, input logic [5:0] v,
        input logic p);
        return {b, v, 19'h0_0000, p};
    endfunction
    task automatic summarize();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One coprocessor access; reserved write bits are always zero
    task automatic cp_op(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
        input logic [2:0] sel, input logic [31:0] wd, input logic [31:0] exp);
        @(negedge clk_in);
        cp_wr_in = wr;
        cp_rd_in = !wr;
        cp_crn_in = crn;
        cp_crm_in = crm;
        cp_sel_in = sel;
        cp_wdata_in = wd;
        #2;
        if (!wr) `CHK(cp_rdata_out, exp)
        @(negedge clk_in);
        cp_wr_in = 1'b0;
        cp_rd_in = 1'b0;
    endtask
    // Raise an access and check its relocated address; the access stays up
    task automatic acc(input logic [31:0] a, input logic ins, input logic [31:0] exp_map);
        @(negedge clk_in);
        access_in = 1'b1;
        access_instr_in = ins;
        core_addr_in = a;
        #2;
        `CHK(mapped_addr_out, exp_map)
    endtask
    // Drop the access and let any refill finish, bounded
    task automatic wait_walk();
        int n;
        n = 0;
        @(negedge clk_in);
        access_in = 1'b0;
        while (walk_req_out !== 1'b0 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        if (walk_req_out !== 1'b0) begin
            err_total++;
            summarize();
        end
    endtask
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        {sys_rst_in, cp_wr_in, cp_rd_in, fetch_in, access_in, access_instr_in} = 6'h20;
        {access_write_in, access_priv_in, cp_crn_in, cp_crm_in, cp_sel_in} = 13'h1000;
        {cp_wdata_in, core_addr_in, mapped_addr_in} = 96'h0;
        {walk_domain_in, walk_ap_in, dly, domain_access_in} = {12'h0FF, 4'h1, 32'h3};
        walk_size_in = SIZE_SECTION;
        flt = 1'b0;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        // Reset values, then separate data and instruction copies
        for (int s = 0; s < 2; s++) cp_op(0, CRN_TLB_LOCK, 4'h0, s[2:0], 0, LOCK_RESET);
        cp_op(0, CRN_CONTEXT, 4'h0, SEL_DATA, 0, 32'h0);
        foreach (rsv[i]) cp_op(0, rsv[i], 4'h0, SEL_DATA, 0, 32'h0);
        cp_op(1, CRN_TLB_LOCK, 4'h0, SEL_DATA, lk(6'h03, 6'h05, 1'b1), 0);
        cp_op(0, CRN_TLB_LOCK, 4'h0, SEL_DATA, 0, lk(6'h03, 6'h05, 1'b1));
        cp_op(0, CRN_TLB_LOCK, 4'h0, SEL_INSTR, 0, 32'h0);
        cp_op(1, CRN_TLB_LOCK, 4'h0, SEL_INSTR, lk(6'h04, 6'h04, 1'b0), 0);
        cp_op(1, CRN_CACHE_LOCK, 4'h0, SEL_INSTR, 32'hA800_0000, 0);
        cp_op(0, CRN_CACHE_LOCK, 4'h0, SEL_INSTR, 0, 32'hA800_0000);
        // Context relocation; instruction side lags by two fetches
        cp_op(1, CRN_CONTEXT, 4'h0, SEL_DATA, 32'h0A00_0000, 0);
        cp_op(0, CRN_CONTEXT, 4'h0, SEL_DATA, 0, 32'h0A00_0000);
        acc(32'h0000_1234, 1'b0, 32'h0A00_1234);
        `CHK({phys_addr_out, cacheable_out, bufferable_out}, {32'h0A00_1234, 2'h0})
        acc(32'h0400_0000, 1'b0, 32'h0400_0000);
        acc(32'h0000_0040, 1'b1, 32'h0000_0040);
        repeat (2) begin
            @(negedge clk_in);
            fetch_in = 1'b1;
            @(negedge clk_in);
            fetch_in = 1'b0;
        end
        acc(32'h0000_0040, 1'b1, 32'h0A00_0040);
        wait_walk();
        // Translation on; a preserved and an unpreserved entry
        cp_op(1, CRN_CONTROL, 4'h0, SEL_DATA, 32'h1, 0);
        cp_op(1, CRN_TLB_LOCK, 4'h0, SEL_DATA, lk(6'h00, 6'h00, 1'b1), 0);
        acc(32'h1000_0000, 1'b0, 32'h1000_0000);
        wait_walk();
        cp_op(1, CRN_TLB_LOCK, 4'h0, SEL_DATA, lk(6'h01, 6'h01, 1'b0), 0);
        acc(32'h2000_0000, 1'b0, 32'h2000_0000);
        wait_walk();
        cp_op(0, CRN_TLB_LOCK, 4'h0, SEL_DATA, 0, lk(6'h01, 6'h02, 1'b0));
        acc(32'h1000_0010, 1'b0, 32'h1000_0010);
        `CHK({hit_out, cache_serve_out, offchip_out}, 3'h6)
        `CHK({cacheable_out, bufferable_out}, 2'h3)
        @(negedge clk_in);
        mapped_addr_in = 32'h1;
        #2 `CHK({offchip_out, phys_addr_out}, {1'b1, 32'h1000_0010})
        @(negedge clk_in);
        domain_access_in = 32'h0;
        #2 `CHK(abort_out, 1'b1)
        @(negedge clk_in);
        domain_access_in = 32'h1;
        #2 `CHK(abort_out, 1'b0)
        @(negedge clk_in);
        domain_access_in = 32'h3;
        mapped_addr_in = 32'h0;
        cp_op(1, CRN_TLB_OPS, CRM_DATA, SEL_DATA, 0, 0);
        acc(32'h1000_0000, 1'b0, 32'h1000_0000);
        `CHK(hit_out, 1'b1)
        acc(32'h2000_0000, 1'b0, 32'h2000_0000);
        `CHK(hit_out, 1'b0)
        wait_walk();
        cp_op(1, CRN_TLB_OPS, CRM_DATA, SEL_INSTR, 32'h1000_0000, 0);
        acc(32'h1000_0000, 1'b0, 32'h1000_0000);
        `CHK(hit_out, 1'b0)
        wait_walk();
        // A faulted walk fills nothing and leaves the victim where it was
        flt = 1'b1;
        acc(32'h5000_0000, 1'b0, 32'h5000_0000);
        wait_walk();
        flt = 1'b0;
        cp_op(0, CRN_TLB_LOCK, 4'h0, SEL_DATA, 0, lk(6'h01, 6'h04, 1'b0));
        acc(32'h5000_0000, 1'b0, 32'h5000_0000);
        `CHK(hit_out, 1'b0)
        wait_walk();
        // Instruction refill walks on the instruction side and advances the instruction victim
        acc(32'h1000_0000, 1'b1, 32'h1000_0000);
        `CHK(hit_out, 1'b0)
        @(negedge clk_in);
        `CHK({walk_req_out, walk_instr_out, walk_addr_out}, {2'h3, 32'h1000_0000})
        wait_walk();
        cp_op(0, CRN_TLB_LOCK, 4'h0, SEL_INSTR, 0, lk(6'h04, 6'h05, 1'b0));
        // Wrap from the last entry back to the base, slower answers each time
        cp_op(1, CRN_TLB_LOCK, 4'h0, SEL_DATA, lk(6'h3E, 6'h3E, 1'b0), 0);
        for (int i = 0; i < 3; i++) begin
            dly = 4'(i * 5);
            acc(32'h3000_0000 + 32'(i) * 32'h0010_0000, 1'b0,
                32'h3000_0000 + 32'(i) * 32'h0010_0000);
            wait_walk();
            cp_op(0, CRN_TLB_LOCK, 4'h0, SEL_DATA, 0,
                lk(6'h3E, i[0] ? 6'h3E : LAST_ENTRY, 1'b0));
        end
        acc(32'h2000_0000, 1'b0, 32'h2000_0000);
        `CHK(hit_out, 1'b1)
        wait_walk();
        summarize();
    end
endmodule

// *** verif/tlb_map_asserts.sv ***
// Checker for the lock-down and context map block, bound to its top module.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/1ns
module tlb_map_asserts (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic cp_wr_in,
    input wire logic cp_rd_in,
    input wire logic [3:0] cp_crn_in,
    input wire logic [31:0] cp_wdata_in,
    input wire logic [31:0] cp_rdata_out,
    input wire logic [31:0] core_addr_in,
    input wire logic access_in,
    input wire logic access_instr_in,
    input wire logic [31:0] mapped_addr_out,
    input wire logic hit_out,
    input wire logic abort_out,
    input wire logic cache_serve_out,
    input wire logic cacheable_out,
    input wire logic bufferable_out,
    input wire logic walk_req_out,
    input wire logic walk_done_in
);
    import tlb_map_pkg::*;
    logic en_ff;
    logic nxt_en;
    logic [6:0] ctx_ff;
    logic [6:0] nxt_ctx;
    // Shadow copies of enable and context, so no check peeks inside
    always_comb begin
        nxt_en = en_ff;
        nxt_ctx = ctx_ff;
        if (cp_wr_in && cp_crn_in == CRN_CONTROL) nxt_en = cp_wdata_in[ENABLE_BIT];
        if (cp_wr_in && cp_crn_in == CRN_CONTEXT) nxt_ctx = cp_wdata_in[31:25];
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            en_ff <= 1'b0;
            ctx_ff <= 7'h00;
        end else begin
            en_ff <= nxt_en;
            ctx_ff <= nxt_ctx;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    rd_idle_zero_a: assert property (!cp_rd_in |-> cp_rdata_out == 32'h0)
        else $error("read data not zero while idle");
    reserved_rd_zero_a: assert property (cp_rd_in &&
        cp_crn_in inside {4'hB, 4'hC, 4'hE, 4'hF} |-> cp_rdata_out == 32'h0)
        else $error("reserved register read not zero");
    lock_rd_gap_a: assert property (cp_rd_in && cp_crn_in == CRN_TLB_LOCK
        |-> cp_rdata_out[19:1] == 19'h0) else $error("lock read gap bits set");
    walk_hold_a: assert property (walk_req_out && !walk_done_in |=> walk_req_out)
        else $error("walk request dropped early");
    walk_end_a: assert property (walk_req_out && walk_done_in |=> !walk_req_out)
        else $error("walk request held after done");
    miss_walk_a: assert property (en_ff && access_in && !hit_out && !walk_req_out
        && !cp_wr_in |=> walk_req_out) else $error("miss started no walk");
    off_no_walk_a: assert property (!en_ff && !walk_req_out |=> !walk_req_out)
        else $error("walk while translation off");
    off_uncached_a: assert property (!en_ff |-> !cacheable_out && !bufferable_out)
        else $error("cacheable while translation off");
    ctx_map_a: assert property (access_in && !access_instr_in |-> mapped_addr_out ==
        ((core_addr_in[31:25] == 7'h00) ? {ctx_ff, core_addr_in[24:0]} : core_addr_in))
        else $error("data address relocation wrong");
    abort_excl_a: assert property (abort_out |-> access_in && en_ff && !cache_serve_out)
        else $error("cache serves an aborted access");
endmodule
bind tlb_lockdown_and_context_map tlb_map_asserts u_chk (.clk_in, .sys_rst_in, .cp_wr_in,
    .cp_rd_in, .cp_crn_in, .cp_wdata_in, .cp_rdata_out, .core_addr_in, .access_in,
    .access_instr_in, .mapped_addr_out, .hit_out, .abort_out, .cache_serve_out,
    .cacheable_out, .bufferable_out, .walk_req_out, .walk_done_in);

// *** verif/tlb_walk_model.sv ***
// Table-walk responder answering each refill request with one section entry.
// Assumes requests stand until done; answer delay is set by the bench.
`timescale 1ns/1ns
module tlb_walk_model (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    input wire logic [3:0] dly_in,
    input wire logic flt_in,
    output logic done_out,
    output logic [31:0] phys_out,
    output logic fault_out,
    output logic cache_out
);
    int cnt;
    initial begin
        done_out = 1'b0;
        phys_out = 32'h0;
        fault_out = 1'b0;
        cache_out = 1'b0;
        cnt = 0;
    end
    // Between requests every data line flips each cycle and holds while counting, so stale values never look valid
    always @(negedge clk_in) begin
        if (sys_rst_in || !req_in || done_out) begin
            done_out <= 1'b0;
            phys_out <= ~phys_out;
            fault_out <= ~fault_out;
            cache_out <= ~cache_out;
            cnt <= 0;
        end else if (cnt >= dly_in) begin
            done_out <= 1'b1;
            phys_out <= {addr_in[31:20], 20'h0_0000};
            fault_out <= flt_in;
            cache_out <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// *** verilog/tlb_lockdown_and_context_map.sv ***
// Lock-down registers, victim selection, entry arrays and context relocation
// for the paired instruction and data translation buffers.
// Assumes the core drives one coprocessor access per strobe, on the core clock,
// and an external walker answers each refill request with one entry.
`timescale 1ns/1ns
// Summary of operation
// - Reset clears both lock-down registers
// - Select 0 picks data, 1 instruction
// - Read returns base, victim, preserve flag
// - Write loads base, victim, preserve together
// - Victim wraps from 63 to base
// - Entries below base refilled only if a write puts victim below base
// - Preserve flag marks entries at load
// - Cache lock-down reads base, writes both
// - Context id resets zero, bits 31:25
// - Low 32MB addresses relocated by context
// - No flush; two fetches keep old id
// - Two 64-entry buffers supply protection
// - Hit: address out, cache, or abort
// - Miss starts walk, fills victim entry
// - Disabled: flat map, uncached, unbuffered
// - Sixteen domains: check, allow, or abort
// - Large/small pages: per-quarter permissions
// - Sections, large, small and tiny pages
// - Buffers lock and flush independently
// - Control bit turns translation on
// - Single invalidate ignores preserve flag
// - Only bits 31:20 and 0 hold state
module tlb_lockdown_and_context_map (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic cp_wr_in,
    input wire logic cp_rd_in,
    input wire logic [3:0] cp_crn_in,
    input wire logic [3:0] cp_crm_in,
    input wire logic [2:0] cp_sel_in,
    input wire logic [31:0] cp_wdata_in,
    output logic [31:0] cp_rdata_out,
    input wire logic [31:0] domain_access_in,
    input wire logic fetch_in,
    input wire logic [31:0] core_addr_in,
    input wire logic access_in,
    input wire logic access_instr_in,
    input wire logic access_write_in,
    input wire logic access_priv_in,
    input wire logic [31:0] mapped_addr_in,
    output logic [31:0] mapped_addr_out,
    output logic hit_out,
    output logic abort_out,
    output logic cache_serve_out,
    output logic offchip_out,
    output logic cacheable_out,
    output logic bufferable_out,
    output logic [31:0] phys_addr_out,
    output logic walk_req_out,
    output logic walk_instr_out,
    output logic [31:0] walk_addr_out,
    input wire logic walk_done_in,
    input wire logic [31:0] walk_phys_in,
    input wire tlb_map_pkg::page_size_type walk_size_in,
    input wire logic [3:0] walk_domain_in,
    input wire logic [7:0] walk_ap_in,
    input wire logic walk_cache_in,
    input wire logic walk_buf_in,
    input wire logic walk_fault_in
);
    import tlb_map_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Index 0 is the data side, index 1 the instruction side
    logic [5:0] base_ff [2], victim_ff [2], cbase_ff [2], cvictim_ff [2];
    logic preserve_ff [2], enable_ff, walk_busy_ff, walk_side_ff;
    logic [6:0] ctx_ff;
    logic [6:0] ctx_hist_ff [CONTEXT_DELAY];
    logic [31:0] walk_addr_ff;
    // Entry arrays, one per side
    logic valid_ff [2][ENTRY_COUNT], keep_ff [2][ENTRY_COUNT];
    logic [21:0] tag_ff [2][ENTRY_COUNT], phys_ff [2][ENTRY_COUNT];
    page_size_type size_ff [2][ENTRY_COUNT];
    logic [3:0] dom_ff [2][ENTRY_COUNT];
    logic [7:0] ap_ff [2][ENTRY_COUNT];
    logic cb_ff [2][ENTRY_COUNT][2];
    // Page mask on the 22-bit tag (address bits 31:10)
    function automatic logic [21:0] size_mask(input page_size_type sz);
        case (sz)
            SIZE_SECTION: size_mask = 22'h3FFC00;
            SIZE_LARGE: size_mask = 22'h3FFFC0;
            SIZE_SMALL: size_mask = 22'h3FFFFC;
            default: size_mask = 22'h3FFFFF;
        endcase
    endfunction
    // Which 2-bit permission field applies for this address
    function automatic logic [1:0] pick_ap(input page_size_type sz, input logic [7:0] ap,
                                           input logic [31:0] a);
        logic [1:0] q;
        q = 2'h0;
        case (sz)
            SIZE_LARGE: q = a[15:14];
            SIZE_SMALL: q = a[11:10];
            default: q = 2'h0;
        endcase
        pick_ap = ap[q*2 +: 2];
    endfunction

    // ------------------------------------------------------------
    // Context relocation
    // ------------------------------------------------------------
    // The id used for fetches lags writes by two fetches, so no flush is needed
    logic [6:0] fetch_ctx;
    logic [31:0] modified_virtual_address;
    always_comb begin
        fetch_ctx = ctx_hist_ff[CONTEXT_DELAY-1];
        modified_virtual_address = core_addr_in;
        if (core_addr_in[31:REGION_LSB] == 7'h00) begin
            modified_virtual_address[31:REGION_LSB] = access_instr_in ? fetch_ctx : ctx_ff;
        end
    end

    // ------------------------------------------------------------
    // Lookup and permission check
    // ------------------------------------------------------------
    logic side, hit, allowed;
    logic [5:0] hit_idx;
    logic [1:0] dom_set, ap;
    logic [31:0] phys;
    always_comb begin
        side = access_instr_in;
        hit = 1'b0;
        hit_idx = 6'h00;
        for (int i = 0; i < ENTRY_COUNT; i++) begin
            if (valid_ff[side][i] && ((modified_virtual_address[31:10] ^ tag_ff[side][i]) &
                size_mask(size_ff[side][i])) == 22'h000000) begin
                hit = 1'b1;
                hit_idx = i[5:0];
            end
        end
        dom_set = domain_access_in[dom_ff[side][hit_idx]*2 +: 2];
        ap = pick_ap(size_ff[side][hit_idx], ap_ff[side][hit_idx], modified_virtual_address);
        // Simplified permission table: 3 full, 2 user read, 1 privileged only
        case (dom_set)
            DOM_MANAGER: allowed = 1'b1;
            DOM_CLIENT: allowed = (ap == 2'h3) || (ap == 2'h2 && (!access_write_in ||
                access_priv_in)) || (ap == 2'h1 && access_priv_in);
            default: allowed = 1'b0;
        endcase
        phys = {(phys_ff[side][hit_idx] & size_mask(size_ff[side][hit_idx])) |
                (modified_virtual_address[31:10] & ~size_mask(size_ff[side][hit_idx])), modified_virtual_address[9:0]};
    end
    // Outcome to core; disabled translation passes flat, uncached
    always_comb begin
        mapped_addr_out = modified_virtual_address;
        phys_addr_out = enable_ff ? phys : modified_virtual_address;
        hit_out = access_in && (!enable_ff || hit);
        abort_out = access_in && enable_ff && hit && !allowed;
        cacheable_out = enable_ff && hit && cb_ff[side][hit_idx][1];
        bufferable_out = enable_ff && hit && cb_ff[side][hit_idx][0];
        cache_serve_out = hit_out && !abort_out && mapped_addr_in[0] == 1'b0 &&
                          cacheable_out;
        offchip_out = hit_out && !abort_out && !cache_serve_out;
    end

    // ------------------------------------------------------------
    // Coprocessor read
    // ------------------------------------------------------------
    // Undefined bits read as zero; other registers answer zero too
    always_comb begin
        cp_rdata_out = 32'h0000_0000;
        if (cp_rd_in) begin
            case (cp_crn_in)
                CRN_TLB_LOCK: cp_rdata_out = {base_ff[cp_sel_in[0]], victim_ff[cp_sel_in[0]],
                    19'h00000, preserve_ff[cp_sel_in[0]]};
                CRN_CACHE_LOCK: cp_rdata_out = {cbase_ff[cp_sel_in[0]], 26'h0};
                CRN_CONTEXT: cp_rdata_out = {ctx_ff, 25'h0};
                CRN_CONTROL: cp_rdata_out = {31'h0, enable_ff};
                default: cp_rdata_out = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register and walk state
    // ------------------------------------------------------------
    logic [5:0] nxt_base [2], nxt_victim [2], nxt_cbase [2], nxt_cvictim [2];
    logic nxt_preserve [2], nxt_enable, nxt_walk_busy, nxt_walk_side, sel_ok, ws;
    logic [6:0] nxt_ctx;
    logic [31:0] nxt_walk_addr;
    always_comb begin
        nxt_base = base_ff;
        nxt_victim = victim_ff;
        nxt_preserve = preserve_ff;
        nxt_cbase = cbase_ff;
        nxt_cvictim = cvictim_ff;
        nxt_ctx = ctx_ff;
        nxt_enable = enable_ff;
        nxt_walk_busy = walk_busy_ff;
        nxt_walk_side = walk_side_ff;
        nxt_walk_addr = walk_addr_ff;
        sel_ok = cp_sel_in == SEL_DATA || cp_sel_in == SEL_INSTR;
        ws = walk_side_ff;
        // Refill advances the victim, reloading base after the last entry
        if (walk_busy_ff && walk_done_in) begin
            nxt_walk_busy = 1'b0;
            if (!walk_fault_in) begin
                nxt_victim[ws] = (victim_ff[ws] == LAST_ENTRY) ? base_ff[ws] :
                                 victim_ff[ws] + 6'h01;
            end
        end else if (!walk_busy_ff && access_in && enable_ff && !hit) begin
            nxt_walk_busy = 1'b1;
            nxt_walk_side = access_instr_in;
            nxt_walk_addr = modified_virtual_address;
        end
        // Writes come after the refill step so a write in the same cycle wins
        if (cp_wr_in && sel_ok) begin
            case (cp_crn_in)
                CRN_TLB_LOCK: begin
                    nxt_base[cp_sel_in[0]] = cp_wdata_in[BASE_LSB +: 6];
                    nxt_victim[cp_sel_in[0]] = cp_wdata_in[VICTIM_LSB +: 6];
                    nxt_preserve[cp_sel_in[0]] = cp_wdata_in[PRESERVE_BIT];
                end
                CRN_CACHE_LOCK: begin
                    nxt_cbase[cp_sel_in[0]] = cp_wdata_in[BASE_LSB +: 6];
                    nxt_cvictim[cp_sel_in[0]] = cp_wdata_in[BASE_LSB +: 6];
                end
                default: ;
            endcase
        end
        if (cp_wr_in && cp_crn_in == CRN_CONTEXT) begin
            nxt_ctx = cp_wdata_in[CONTEXT_LSB +: 7];
        end
        if (cp_wr_in && cp_crn_in == CRN_CONTROL) begin
            nxt_enable = cp_wdata_in[ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int s = 0; s < 2; s++) begin
                base_ff[s] <= LOCK_RESET[BASE_LSB +: 6];
                victim_ff[s] <= LOCK_RESET[VICTIM_LSB +: 6];
                preserve_ff[s] <= LOCK_RESET[PRESERVE_BIT];
                cbase_ff[s] <= 6'h00;
                cvictim_ff[s] <= 6'h00;
            end
            ctx_ff <= CONTEXT_RESET;
            enable_ff <= 1'b0;
            walk_busy_ff <= 1'b0;
            walk_side_ff <= 1'b0;
            walk_addr_ff <= 32'h0000_0000;
        end else begin
            base_ff <= nxt_base;
            victim_ff <= nxt_victim;
            preserve_ff <= nxt_preserve;
            cbase_ff <= nxt_cbase;
            cvictim_ff <= nxt_cvictim;
            ctx_ff <= nxt_ctx;
            enable_ff <= nxt_enable;
            walk_busy_ff <= nxt_walk_busy;
            walk_side_ff <= nxt_walk_side;
            walk_addr_ff <= nxt_walk_addr;
        end
    end

    // Context history shifts one step per fetch
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int k = 0; k < CONTEXT_DELAY; k++) begin
                ctx_hist_ff[k] <= CONTEXT_RESET;
            end
        end else if (fetch_in) begin
            ctx_hist_ff[0] <= ctx_ff;
            for (int k = 1; k < CONTEXT_DELAY; k++) begin
                ctx_hist_ff[k] <= ctx_hist_ff[k-1];
            end
        end
    end

    assign walk_req_out = walk_busy_ff;
    assign walk_instr_out = walk_side_ff;
    assign walk_addr_out = walk_addr_ff;
    // ------------------------------------------------------------
    // Entry arrays: fill and invalidate
    // ------------------------------------------------------------
    // Payload arrays carry no reset; valid bits alone qualify them
    logic inv_op, inv_single;
    logic inv_side [2];
    always_comb begin
        inv_op = cp_wr_in && cp_crn_in == CRN_TLB_OPS;
        inv_side[0] = inv_op && (cp_crm_in == CRM_BOTH || cp_crm_in == CRM_DATA);
        inv_side[1] = inv_op && (cp_crm_in == CRM_BOTH || cp_crm_in == CRM_INSTR);
        inv_single = cp_sel_in == SEL_INSTR && cp_crm_in != CRM_BOTH;
    end

    for (genvar s = 0; s < 2; s++) begin : g_side
        for (genvar e = 0; e < ENTRY_COUNT; e++) begin : g_entry
            logic fill, nxt_valid, nxt_keep;
            always_comb begin
                fill = walk_busy_ff && walk_done_in && !walk_fault_in &&
                       walk_side_ff == 1'(s) && victim_ff[s] == 6'(e);
                nxt_valid = valid_ff[s][e];
                nxt_keep = keep_ff[s][e];
                if (inv_side[s] && !inv_single && !keep_ff[s][e]) begin
                    nxt_valid = 1'b0;
                end
                if (inv_side[s] && inv_single && ((cp_wdata_in[31:10] ^ tag_ff[s][e]) &
                    size_mask(size_ff[s][e])) == 22'h000000) begin
                    nxt_valid = 1'b0;
                end
                if (fill) begin
                    nxt_valid = 1'b1;
                    nxt_keep = preserve_ff[s];
                end
            end
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    valid_ff[s][e] <= 1'b0;
                    keep_ff[s][e] <= 1'b0;
                end else begin
                    valid_ff[s][e] <= nxt_valid;
                    keep_ff[s][e] <= nxt_keep;
                end
            end
            always_ff @(posedge clk_in) begin
                if (fill) begin
                    tag_ff[s][e] <= walk_addr_ff[31:10];
                    phys_ff[s][e] <= walk_phys_in[31:10];
                    size_ff[s][e] <= walk_size_in;
                    dom_ff[s][e] <= walk_domain_in;
                    ap_ff[s][e] <= walk_ap_in;
                    cb_ff[s][e][1] <= walk_cache_in;
                    cb_ff[s][e][0] <= walk_buf_in;
                end
            end
        end
    end
endmodule
